//--- shared/ftr_regs.svh
// constants for the fault trigger recorder control block
`ifndef FTR_REGS_SVH
`define FTR_REGS_SVH
`define FTR_N_ANALOG 8
`define FTR_N_DIN 48
`define FTR_PCT_W 11
`define FTR_MEAS_W 16
`define FTR_PCT_FULL 11'h3E8
`define FTR_THR_MAX 11'h7D0
`define FTR_HYS_MAX 11'h1F4
`define FTR_HYS_DEF 11'h032
`define FTR_WAVE_DEF 3'h6
`define FTR_MAXDUR_DEF 14'h0064
`define FTR_MAXDUR_MAX 14'h2710
`define FTR_PRE_DEF 5'h04
`define FTR_POST_DEF 5'h04
`define FTR_CYC_MAX 5'h14
`define FTR_TREND_LOG 4'hD
`define FTR_ADDR_CTRL 8'h00
`define FTR_ADDR_TRIGEN 8'h04
`define FTR_ADDR_WAVE 8'h08
`define FTR_ADDR_TREND 8'h0C
`define FTR_ADDR_CYC 8'h10
`define FTR_ADDR_STATUS 8'h14
`define FTR_ADDR_LINK_LO 8'h18
`define FTR_ADDR_LINK_HI 8'h1C
`define FTR_ADDR_THR0 8'h40
`define FTR_ADDR_HYS0 8'h60
`define FTR_TRIGEN_DEF 8'hE7
`define FTR_IDX_OVERCUR 3
`define FTR_IDX_UNDERV2 1
`define FTR_IDX_ZSEQ 3'h3
`define FTR_IDX_VUNB 3'h4
`endif

//--- shared/ftr_pkg.sv
// types for the fault trigger recorder control block
package ftr_pkg;
  typedef enum logic [2:0] {
    FTR_IDLE = 3'b001,
    FTR_ACTIVE = 3'b010,
    FTR_POST = 3'b100
  } ftr_state_t;
  typedef struct packed {
    logic wave_start;
    logic wave_end;
    logic [2:0] wave_file;
    logic fault_log;
    logic soe_log;
    logic quality_log;
  } ftr_log_req_t;
  typedef struct packed {
    logic trend_on;
    logic [3:0] trend_file;
    logic [4:0] pre_cycles;
  } ftr_trend_t;
endpackage

//--- logic/ftr_fault_recorder.sv
// fault trigger recorder control: triggers, flags and log requests
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`include "ftr_regs.svh"
module ftr_fault_recorder
  import ftr_pkg::*;
#(
  parameter int N_ANALOG = `FTR_N_ANALOG,
  parameter int N_DIN = `FTR_N_DIN,
  parameter int MW = `FTR_MEAS_W
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // measurement front end, one value per analog trigger
  input wire logic [N_ANALOG*MW-1:0] meas,
  input wire logic [N_ANALOG-1:0] trig_is_under,
  input wire logic [N_ANALOG-1:0] trig_is_volt,
  input wire logic [N_ANALOG-1:0] trig_is_curr,
  input wire logic [MW-1:0] ref_ln_volt,
  input wire logic [MW-1:0] ref_ll_volt,
  input wire logic [MW-1:0] ref_ct_curr,
  input wire logic wye_four_wire_wiring,
  input wire logic wye_three_element_wiring,
  input wire logic wye_balanced_wiring,
  input wire logic [N_DIN-1:0] din,
  input wire logic half_cycle_tick,
  output logic fault_detected,
  output logic external_trigger,
  output logic fault_event,
  output ftr_log_req_t log_req,
  output ftr_trend_t trend,
  output logic [N_ANALOG-1:0] trig_state
);
  logic rec_en_q;
  logic quality_log_copy_on_q;
  logic [N_ANALOG-1:0] trig_en_q;
  logic wave_start_on_q;
  logic wave_end_on_q;
  logic [2:0] wave_file_q;
  logic trend_en_q;
  logic [13:0] max_dur_q;
  logic [4:0] pre_q;
  logic [4:0] post_q;
  logic [N_DIN-1:0] din_link_q;
  logic [`FTR_PCT_W-1:0] thr_q [N_ANALOG];
  logic [`FTR_PCT_W-1:0] hys_q [N_ANALOG];
  logic [N_ANALOG-1:0] trig_q;
  logic [N_ANALOG-1:0] qual_src;
  logic [N_ANALOG-1:0] eff_trig;
  logic internal_d;
  logic external_d;
  logic event_d;
  logic event_prev_q;
  logic quality_d;
  logic quality_prev_q;
  logic thr_sel;
  logic hys_sel;
  ftr_state_t state_q;
  logic [14:0] dur_q;
  logic [5:0] post_cnt_q;
  logic [MW-1:0] volt_ref;
  logic [2:0] widx;
  logic [2:0] ridx;

  assign widx = reg_addr[4:2];
  assign ridx = reg_addr[4:2];
  assign thr_sel = reg_addr[7:5] == 3'(`FTR_ADDR_THR0 >> 5);
  assign hys_sel = reg_addr[7:5] == 3'(`FTR_ADDR_HYS0 >> 5);

  // wye wirings use phase-to-neutral reference
  assign volt_ref = (wye_four_wire_wiring || wye_three_element_wiring ||
                     wye_balanced_wiring) ? ref_ln_volt : ref_ll_volt;

  // global enable and quality log copy
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rec_en_q <= 1'b1;
      quality_log_copy_on_q <= 1'b1;
    end else if (clk_en && reg_wr && reg_addr == `FTR_ADDR_CTRL) begin
      rec_en_q <= reg_wdata[0];
      quality_log_copy_on_q <= reg_wdata[1];
    end
  end

  // per-trigger enables, zero-sequence and unbalance start off
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      trig_en_q <= N_ANALOG'(`FTR_TRIGEN_DEF);
    end else if (clk_en && reg_wr && reg_addr == `FTR_ADDR_TRIGEN) begin
      trig_en_q <= reg_wdata[N_ANALOG-1:0];
    end
  end

  // waveform capture options
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wave_start_on_q <= 1'b1;
      wave_end_on_q <= 1'b0;
      wave_file_q <= `FTR_WAVE_DEF;
    end else if (clk_en && reg_wr && reg_addr == `FTR_ADDR_WAVE) begin
      wave_start_on_q <= reg_wdata[0];
      wave_end_on_q <= reg_wdata[1];
      wave_file_q <= reg_wdata[6:4];
    end
  end

  // trend enable and cycle limit, out-of-range limit refused
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      trend_en_q <= 1'b0;
      max_dur_q <= `FTR_MAXDUR_DEF;
    end else if (clk_en && reg_wr && reg_addr == `FTR_ADDR_TREND) begin
      trend_en_q <= reg_wdata[0];
      if (reg_wdata[29:16] <= `FTR_MAXDUR_MAX) begin
        max_dur_q <= reg_wdata[29:16];
      end
    end
  end

  // pre- and post-event cycle counts, each refused above the limit
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= `FTR_PRE_DEF;
      post_q <= `FTR_POST_DEF;
    end else if (clk_en && reg_wr && reg_addr == `FTR_ADDR_CYC) begin
      if (reg_wdata[4:0] <= `FTR_CYC_MAX) begin
        pre_q <= reg_wdata[4:0];
      end
      if (reg_wdata[12:8] <= `FTR_CYC_MAX) begin
        post_q <= reg_wdata[12:8];
      end
    end
  end

  // digital input links, low and high words
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      din_link_q <= '0;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `FTR_ADDR_LINK_LO) begin
        din_link_q[31:0] <= reg_wdata;
      end
      if (reg_addr == `FTR_ADDR_LINK_HI) begin
        din_link_q[N_DIN-1:32] <= reg_wdata[N_DIN-33:0];
      end
    end
  end

  // threshold bank, values above twice full range refused
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < N_ANALOG; i++) begin
        thr_q[i] <= `FTR_PCT_FULL;
      end
    end else if (clk_en && reg_wr && thr_sel &&
                 reg_wdata[`FTR_PCT_W-1:0] <= `FTR_THR_MAX) begin
      thr_q[widx] <= reg_wdata[`FTR_PCT_W-1:0];
    end
  end

  // hysteresis bank, values above half of full range refused
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < N_ANALOG; i++) begin
        hys_q[i] <= `FTR_HYS_DEF;
      end
    end else if (clk_en && reg_wr && hys_sel &&
                 reg_wdata[`FTR_PCT_W-1:0] <= `FTR_HYS_MAX) begin
      hys_q[widx] <= reg_wdata[`FTR_PCT_W-1:0];
    end
  end

  // analog comparators with hysteresis, in tenths of a percent
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      trig_q <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < N_ANALOG; i++) begin
        logic [MW-1:0] ref_v;
        logic [MW+`FTR_PCT_W-1:0] m_scaled;
        logic [MW+`FTR_PCT_W-1:0] thr_s;
        logic [MW+2*`FTR_PCT_W-1:0] hys_s;
        logic [MW+2*`FTR_PCT_W-1:0] m_wide;
        logic [MW+2*`FTR_PCT_W-1:0] on_lvl;
        logic [MW+2*`FTR_PCT_W-1:0] off_lo;
        logic [MW+2*`FTR_PCT_W-1:0] off_hi;
        // current triggers incl. unbalance use rated current
        ref_v = trig_is_curr[i] ? ref_ct_curr : volt_ref;
        m_scaled = (MW+`FTR_PCT_W)'(meas[i*MW +: MW]) * `FTR_PCT_FULL;
        thr_s = (MW+`FTR_PCT_W)'(ref_v) * thr_q[i];
        hys_s = (MW+2*`FTR_PCT_W)'(thr_s) * hys_q[i];
        m_wide = (MW+2*`FTR_PCT_W)'(m_scaled) * `FTR_PCT_FULL;
        on_lvl = (MW+2*`FTR_PCT_W)'(thr_s) * `FTR_PCT_FULL;
        off_lo = on_lvl - hys_s;
        off_hi = on_lvl + hys_s;
        if (!trig_en_q[i]) begin
          trig_q[i] <= 1'b0;
        end else if (trig_is_under[i]) begin
          if (m_wide < on_lvl) begin
            trig_q[i] <= 1'b1;
          end else if (m_wide > off_hi) begin
            trig_q[i] <= 1'b0;
          end
        end else begin
          if (m_wide > on_lvl) begin
            trig_q[i] <= 1'b1;
          end else if (m_wide < off_lo) begin
            trig_q[i] <= 1'b0;
          end
        end
      end
    end
  end

  // overcurrent gated by second undervoltage when enabled
  always_comb begin
    eff_trig = trig_q;
    if (trig_en_q[`FTR_IDX_UNDERV2]) begin
      eff_trig[`FTR_IDX_OVERCUR] = trig_q[`FTR_IDX_OVERCUR] &
                                   trig_q[`FTR_IDX_UNDERV2];
      eff_trig[`FTR_IDX_UNDERV2] = 1'b0;
    end
  end

  assign qual_src = eff_trig & (trig_is_volt | trig_is_curr);
  assign internal_d = rec_en_q && (|eff_trig);
  assign external_d = rec_en_q && (|(din & din_link_q));
  assign event_d = internal_d || external_d;
  assign quality_d = rec_en_q && quality_log_copy_on_q && (|qual_src);

  // static fault flags
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fault_detected <= 1'b0;
      external_trigger <= 1'b0;
      fault_event <= 1'b0;
      event_prev_q <= 1'b0;
      quality_prev_q <= 1'b0;
      trig_state <= '0;
    end else if (clk_en) begin
      fault_detected <= internal_d;
      external_trigger <= external_d;
      fault_event <= event_d;
      event_prev_q <= event_d;
      quality_prev_q <= quality_d;
      trig_state <= eff_trig;
    end
  end

  // log requests, one-cycle pulses
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      log_req <= '0;
    end else if (clk_en) begin
      log_req.wave_file <= wave_file_q;
      log_req.wave_start <= event_d && !event_prev_q && wave_start_on_q;
      log_req.wave_end <= !event_d && event_prev_q && wave_end_on_q;
      log_req.fault_log <= event_d && !event_prev_q;
      log_req.soe_log <= event_d && !event_prev_q;
      log_req.quality_log <= quality_d && !quality_prev_q;
    end
  end

  // half-cycle trend sequencer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= FTR_IDLE;
      dur_q <= '0;
      post_cnt_q <= '0;
      trend <= '0;
    end else if (clk_en) begin
      trend.trend_file <= `FTR_TREND_LOG;
      trend.pre_cycles <= pre_q;
      case (state_q)
        FTR_IDLE: begin
          trend.trend_on <= 1'b0;
          if (event_d && !event_prev_q && trend_en_q) begin
            state_q <= FTR_ACTIVE;
            dur_q <= '0;
            trend.trend_on <= 1'b1;
          end
        end
        FTR_ACTIVE: begin
          if (!event_d || dur_q >= {max_dur_q, 1'b0}) begin
            state_q <= FTR_POST;
            post_cnt_q <= '0;
          end else if (half_cycle_tick) begin
            dur_q <= dur_q + 15'h0001;
          end
        end
        FTR_POST: begin
          if (post_cnt_q >= {post_q, 1'b0}) begin
            state_q <= FTR_IDLE;
            trend.trend_on <= 1'b0;
          end else if (half_cycle_tick) begin
            post_cnt_q <= post_cnt_q + 6'h01;
          end
        end
        default: state_q <= FTR_IDLE;
      endcase
    end
  end

  // register read, data one cycle after strobe
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= '0;
      case (reg_addr)
        `FTR_ADDR_CTRL: reg_rdata <= {30'h0, quality_log_copy_on_q, rec_en_q};
        `FTR_ADDR_TRIGEN: reg_rdata <= 32'(trig_en_q);
        `FTR_ADDR_WAVE:
          reg_rdata <= {25'h0, wave_file_q, 2'h0, wave_end_on_q,
                        wave_start_on_q};
        `FTR_ADDR_TREND: reg_rdata <= {2'h0, max_dur_q, 15'h0, trend_en_q};
        `FTR_ADDR_CYC: reg_rdata <= {19'h0, post_q, 3'h0, pre_q};
        `FTR_ADDR_STATUS:
          reg_rdata <= {13'h0, state_q, trig_q, 5'h0, fault_event,
                        external_trigger, fault_detected};
        `FTR_ADDR_LINK_LO: reg_rdata <= din_link_q[31:0];
        `FTR_ADDR_LINK_HI: reg_rdata <= 32'(din_link_q[N_DIN-1:32]);
        default: begin
          if (thr_sel) begin
            reg_rdata <= 32'(thr_q[ridx]);
          end else if (hys_sel) begin
            reg_rdata <= 32'(hys_q[ridx]);
          end
        end
      endcase
    end
  end
endmodule

//--- bench/ftr_din_model.sv
// far side model: linked digital inputs fed over relay contacts
`timescale 1ns/10ps
module ftr_din_model (
  input wire logic core_clk,
  input wire logic own_relay,
  input wire logic [47:0] remote_fault,
  output logic [47:0] din
);
  // own input opens on the closed-side contact while signalling
  always_ff @(posedge core_clk) begin
    din <= own_relay ? 48'h0 : remote_fault;
  end
endmodule

//--- bench/ftr_fault_recorder_chk.sv
// port checker for the fault recorder
`timescale 1ns/10ps
`include "ftr_regs.svh"
module ftr_fault_recorder_chk
  import ftr_pkg::*;
#(
  parameter int N_ANALOG = 8,
  parameter int N_DIN = 48
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [N_DIN-1:0] din,
  input wire logic fault_detected,
  input wire logic external_trigger,
  input wire logic fault_event,
  input wire ftr_log_req_t log_req,
  input wire ftr_trend_t trend,
  input wire logic [N_ANALOG-1:0] trig_state
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence rec_off_s;
    clk_en && reg_wr && reg_addr == `FTR_ADDR_CTRL && !reg_wdata[0];
  endsequence
  sequence no_din_s;
    (clk_en && din == '0) [*2];
  endsequence
  event_or_a: assert property (
    fault_event == (fault_detected | external_trigger))
    else $error("fault event differs from its sources");
  global_off_a: assert property (
    rec_off_s |-> ##2 !fault_event) else $error("recorder still flags");
  log_pair_a: assert property (
    log_req.fault_log == log_req.soe_log) else $error("log pair split");
  event_log_a: assert property (
    $rose(fault_event) |-> log_req.fault_log && log_req.soe_log)
    else $error("event start not logged");
  trend_file_a: assert property (
    trend.trend_on |-> trend.trend_file == `FTR_TREND_LOG)
    else $error("trend file wrong");
  pre_max_a: assert property (
    trend.pre_cycles <= `FTR_CYC_MAX) else $error("pre cycles too large");
  no_link_a: assert property (
    no_din_s |-> !external_trigger) else $error("external without input");
  trig_gate_a: assert property (
    (trig_state == '0) [*2] |-> !fault_detected)
    else $error("fault without trigger");
  wave_pulse_a: assert property (
    log_req.wave_start |=> !log_req.wave_start) else $error("wave pulse long");
endmodule
bind ftr_fault_recorder ftr_fault_recorder_chk #(.N_ANALOG(N_ANALOG),
  .N_DIN(N_DIN)) u_chk (.core_clk(core_clk), .resetn(resetn),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .din(din), .fault_detected(fault_detected),
  .external_trigger(external_trigger), .fault_event(fault_event),
  .log_req(log_req), .trend(trend), .trig_state(trig_state));

//--- bench/test_fault_trigger_recorder_control.sv
// self-checking bench for the fault recorder
`timescale 1ns/10ps
`include "ftr_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module test_fault_trigger_recorder_control
  import ftr_pkg::*;
;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tick = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [127:0] meas = 128'h0;
  logic [2:0] wir = 3'h0;
  logic [47:0] din;
  logic [47:0] remote = 48'h0;
  logic [7:0] trig_state;
  logic fault_detected, external_trigger, fault_event;
  logic seen_f = 1'b0, seen_q = 1'b0, seen_w = 1'b0;
  logic seen_e = 1'b0, seen_t = 1'b0;
  logic [7:0] curr = 8'h00;
  logic cen = 1'b1;
  ftr_log_req_t log_req;
  ftr_trend_t trend;
  int fail_count = 0;
  int n_checks = 0;
  logic [7:0] da [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h40, 8'h60,
    8'h30};
  logic [31:0] de [8] = '{32'h3, 32'hE7, 32'h61, 32'h640000, 32'h404,
    32'h3E8, 32'h32, 32'h0};
  logic [7:0] la [7] = '{8'h40, 8'h40, 8'h40, 8'h60, 8'h0C, 8'h0C, 8'h10};
  logic [31:0] lw [7] = '{32'h7D0, 32'h7D1, 32'h3E8, 32'h1F5, 32'h27110000,
    32'h27100001, 32'h415};
  logic [31:0] le [7] = '{32'h7D0, 32'h7D0, 32'h3E8, 32'h32, 32'h640000,
    32'h27100001, 32'h404};
  logic [15:0] mv [3] = '{16'h044C, 16'h03C0, 16'h0384};
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    tick <= ~tick;
    seen_f <= seen_f | log_req.fault_log;
    seen_q <= seen_q | log_req.quality_log;
    seen_w <= seen_w | log_req.wave_start;
    seen_e <= seen_e | log_req.wave_end;
    seen_t <= seen_t | trend.trend_on;
  end
  ftr_fault_recorder DUT (.core_clk(core_clk), .resetn(resetn),
    .clk_en(cen), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas(meas),
    .trig_is_under(8'h00), .trig_is_volt(8'hFF), .trig_is_curr(curr),
    .ref_ln_volt(16'h01F4), .ref_ll_volt(16'h03E8), .ref_ct_curr(16'h03E8),
    .wye_four_wire_wiring(wir[0]), .wye_three_element_wiring(wir[1]),
    .wye_balanced_wiring(wir[2]), .din(din), .half_cycle_tick(tick),
    .fault_detected(fault_detected), .external_trigger(external_trigger),
    .fault_event(fault_event), .log_req(log_req), .trend(trend),
    .trig_state(trig_state));
  ftr_din_model u_din (.core_clk(core_clk), .own_relay(fault_detected),
    .remote_fault(remote), .din(din));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, string nm);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    `CHK(nm, e, reg_rdata)
  endtask
  // flags and the relay loop settle within four cycles
  task automatic wt;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) rc(da[i], de[i], "default");
    for (int i = 0; i < 7; i++) begin
      wr(la[i], lw[i]);
      rc(la[i], le[i], "limit");
    end
    $display("test registers done");
    wr(`FTR_ADDR_WAVE, 32'h23);
    wr(`FTR_ADDR_LINK_HI, 32'h8000);
    remote <= 48'h1;
    wt;
    `CHK("unlinked", 1'b0, external_trigger)
    remote <= 48'h8000_0000_0000;
    wr(`FTR_ADDR_TRIGEN, 32'h0);
    wt;
    `CHK("ext", 1'b1, external_trigger)
    `CHK("detected", 1'b0, fault_detected)
    `CHK("wave file", 3'h2, log_req.wave_file)
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    `CHK("event held", 1'b1, fault_event)
    wr(`FTR_ADDR_CTRL, 32'h2);
    wt;
    `CHK("global off", 1'b0, fault_event)
    wr(`FTR_ADDR_CTRL, 32'h3);
    wr(`FTR_ADDR_TRIGEN, 32'hE7);
    $display("test external done");
    for (int i = 0; i < 3; i++) begin
      meas[15:0] <= mv[i];
      wt;
      `CHK("hysteresis", i < 2, fault_detected)
      if (i == 0) `CHK("relay open", 1'b0, external_trigger)
    end
    remote <= 48'h0;
    `CHK("logs", 4'hF, {seen_f, seen_q, seen_w, seen_e})
    `CHK("trend on", 1'b1, seen_t)
    `CHK("trend file", `FTR_TREND_LOG, trend.trend_file)
    `CHK("pre cycles", `FTR_PRE_DEF, trend.pre_cycles)
    wr(`FTR_ADDR_TRIGEN, 32'hE6);
    meas[15:0] <= mv[0];
    wt;
    `CHK("disabled", 1'b0, fault_detected)
    wr(`FTR_ADDR_TRIGEN, 32'hE7);
    wt;
    `CHK("enabled", 1'b1, fault_detected)
    meas[15:0] <= 16'h0258;
    for (int i = 0; i < 4; i++) begin
      wir <= (i < 3) ? (3'h1 << i) : 3'h0;
      wt;
      `CHK("wiring", i < 3, fault_detected)
    end
    curr <= 8'h01;
    wir <= 3'h1;
    wt;
    `CHK("current ref", 1'b0, fault_detected)
    curr <= 8'h00;
    wt;
    `CHK("voltage ref", 1'b1, fault_detected)
    cen <= 1'b0;
    meas <= 128'h0;
    wt;
    `CHK("frozen", 1'b1, fault_detected)
    cen <= 1'b1;
    wt;
    `CHK("released", 1'b0, fault_detected)
    wir <= 3'h0;
    wr(`FTR_ADDR_TRIGEN, 32'h0A);
    meas[63:48] <= 16'h044C;
    wt;
    `CHK("and gate", 1'b0, fault_detected)
    meas[31:16] <= 16'h044C;
    wt;
    `CHK("and pair", 1'b1, fault_detected)
    wr(`FTR_ADDR_TRIGEN, 32'h08);
    wt;
    `CHK("overcurrent alone", 1'b1, fault_detected)
    `CHK("trig state", 8'h08, trig_state)
    meas <= 128'h0;
    $display("test analog done");
    complete_run;
  end
endmodule
